// *** rtl/bank_pkg.sv ***
// bank_pkg: shared constants, command codes and carrier structs for the bank controller.
// assumes a single 125 MHz clock; commands arrive already registered on that clock.
//
// Summary of operation
// - write cut by precharge stores only pairs before recovery; later data masked; code stores every element before the precharge command
// - one data strobe per byte lane; lane n covers bits 8n+7:8n
// - one write mask per byte lane; lane n covers bits 8n+7:8n
// - precharge: addr bit 10 low closes selected bank, high closes all
// - precharge to idle or already precharging bank acts as no-operation
// - addr bit 10 on read/write requests auto precharge for that command
// - auto precharge starts at earliest legal explicit precharge point
// - read auto precharge starts where earliest full-burst precharge would
// - write auto precharge starts after write recovery, at least one clock
// - auto precharge held off until minimum row-active time has passed
// - commands to other banks accepted while a bank auto precharges
// - auto refresh uses internal row counter, ignores address inputs
// - data with mask low stored, mask high discarded
// - read auto precharge starts burst-length/2 clocks after read
package bank_pkg;

	localparam int NBANK     = 4;
	localparam int ROW_W     = 13;
	localparam int COL_W     = 10;
	localparam int DQ_W      = 32;
	localparam int LANES     = DQ_W / 8;
	localparam int CLK_PS    = 8000;

	// ---------------------------------------------------------------
	// timing, in ps as printed by the device grade, and clock counts
	// ---------------------------------------------------------------
	localparam int T_RP_PS   = 15000;
	localparam int T_RAS_PS  = 40000;
	localparam int T_WR_PS   = 15000;
	localparam int T_RFC_PS  = 72000;
	localparam int RP_CYC    = (T_RP_PS + CLK_PS - 1) / CLK_PS;
	localparam int RAS_CYC   = (T_RAS_PS + CLK_PS - 1) / CLK_PS;
	localparam int WR_CYC    = (T_WR_PS + CLK_PS - 1) / CLK_PS;
	localparam int RFC_CYC   = (T_RFC_PS + CLK_PS - 1) / CLK_PS;
	localparam int TMR_W     = 5;

	localparam logic [2:0] BL_RST = 3'h4;
	localparam logic [ROW_W-1:0] RFROW_RST = 13'h0000;
	localparam int AP_BIT    = 10;

	typedef enum logic [2:0] {
		CMD_NOP  = 3'h0,
		CMD_ACT  = 3'h1,
		CMD_RD   = 3'h2,
		CMD_WR   = 3'h3,
		CMD_PRE  = 3'h4,
		CMD_REF  = 3'h5
	} cmd_t;

	// gray codes along idle -> active -> precharging; the return from precharging to idle flips both bits
	typedef enum logic [1:0] {
		BK_IDLE  = 2'h0,
		BK_ACT   = 2'h1,
		BK_PRE   = 2'h3
	} bank_st_t;

	typedef struct packed {
		cmd_t                  cmd;
		logic [1:0]            ba;
		logic [ROW_W-1:0]      addr;
	} cmd_bus_t;

	typedef struct packed {
		logic [DQ_W-1:0]       data;
		logic [LANES-1:0]      mask;
	} wdata_t;

endpackage

// *** rtl/bank_timer.sv ***
// bank_timer: one bank's state, its row-active and precharge timers and an auto precharge flag.
// assumes the parent decodes commands and the burst end for this bank.
module bank_timer (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_b,
	// decoded events for this bank
	input  wire logic               act_i,
	input  wire logic               pre_i,
	input  wire logic               ap_arm_i,
	input  wire logic               ap_fire_i,
	// state out
	output bank_pkg::bank_st_t      state_o,
	output logic                    ras_ok_o
);
	bank_pkg::bank_st_t             state_r;
	logic [bank_pkg::TMR_W-1:0]     ras_r;
	logic [bank_pkg::TMR_W-1:0]     rp_r;
	logic                           ap_r;

	assign state_o  = state_r;
	assign ras_ok_o = (ras_r == '0);

	// ---------------------------------------------------------------
	// bank state
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= bank_pkg::BK_IDLE;
		end else begin
			unique case (state_r)
				bank_pkg::BK_IDLE: begin
					if (act_i) begin
						state_r <= bank_pkg::BK_ACT;
					end
				end
				bank_pkg::BK_ACT: begin
					// explicit or automatic close, row-active time enforced by parent on the automatic one only
					if (pre_i || ap_fire_i) begin
						state_r <= bank_pkg::BK_PRE;
					end
				end
				bank_pkg::BK_PRE: begin
					if (rp_r == 5'h01) begin
						state_r <= bank_pkg::BK_IDLE;
					end
				end
				default: state_r <= bank_pkg::BK_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// row-active and precharge timers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ras_r <= '0;
		end else if (act_i && state_r == bank_pkg::BK_IDLE) begin
			ras_r <= bank_pkg::TMR_W'(bank_pkg::RAS_CYC - 1);
		end else if (ras_r != '0) begin
			ras_r <= ras_r - 5'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rp_r <= '0;
		end else if (state_r == bank_pkg::BK_ACT && (pre_i || ap_fire_i)) begin
			rp_r <= bank_pkg::TMR_W'(bank_pkg::RP_CYC);
		end else if (rp_r != '0) begin
			rp_r <= rp_r - 5'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ap_r <= 1'b0;
		end else if (ap_arm_i) begin
			ap_r <= 1'b1;
		end else if (ap_fire_i) begin
			ap_r <= 1'b0;
		end
	end

	// precharge never leaves a bank open early
	a_pre_period: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(state_r == bank_pkg::BK_PRE) |-> (state_r == bank_pkg::BK_PRE) [*2])
		else $error("precharge period cut short");

	// an armed auto precharge always lands in the precharge state
	a_ap_close: assert property (@(posedge clk) disable iff (!rst_b)
		(ap_r && ap_fire_i) |=> state_r == bank_pkg::BK_PRE)
		else $error("armed auto precharge did not close the row");

endmodule

// *** rtl/refresh_ctr.sv ***
// refresh_ctr: internal refresh row counter and refresh busy timer.
// assumes the parent only pulses ref_i on a registered refresh command.
module refresh_ctr (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	// refresh request
	input  wire logic                     ref_i,
	// status
	output logic [bank_pkg::ROW_W-1:0]    row_o,
	output logic                          busy_o
);
	logic [bank_pkg::ROW_W-1:0]     row_r;
	logic [bank_pkg::TMR_W+1:0]     rfc_r;

	assign row_o  = row_r;
	assign busy_o = (rfc_r != '0);

	// row comes from the counter alone; address pins never reach here
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			row_r <= bank_pkg::RFROW_RST;
		end else if (ref_i) begin
			row_r <= row_r + 13'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rfc_r <= '0;
		end else if (ref_i) begin
			rfc_r <= 7'(bank_pkg::RFC_CYC);
		end else if (rfc_r != '0) begin
			rfc_r <= rfc_r - 7'h01;
		end
	end

	a_ref_row_step: assert property (@(posedge clk) disable iff (!rst_b)
		ref_i |=> row_r == $past(row_r) + 13'h0001)
		else $error("refresh row did not advance");

endmodule

// *** rtl/bank_ctrl.sv ***
// bank_ctrl: bank state, precharge, auto precharge, write truncation and refresh.
// assumes commands, strobes and masks are already registered on clk by the pin layer.
module bank_ctrl (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	// command from the controller
	input  wire logic                     cke,
	input  wire bank_pkg::cmd_bus_t       cmd_in,
	// write data, one element per strobe edge
	input  wire logic                     wd_valid,
	input  wire bank_pkg::wdata_t         wd_in,
	// burst length, fixed per mode
	input  wire logic [4:0]               burst_len,
	// array write port
	output logic                          arr_we,
	output logic [1:0]                    arr_ba,
	output logic [bank_pkg::COL_W-1:0]    arr_col,
	output logic [bank_pkg::DQ_W-1:0]     arr_data,
	output logic [bank_pkg::DQ_W-1:0]     arr_bit_en,
	// status
	output bank_pkg::bank_st_t            bank_state [bank_pkg::NBANK],
	output logic                          ref_busy,
	output logic [bank_pkg::ROW_W-1:0]    ref_row
);
	logic                           cmd_ok;
	logic                           is_act;
	logic                           is_rd;
	logic                           is_wr;
	logic                           is_pre;
	logic                           is_ref;
	logic                           ap_flag;
	logic [bank_pkg::NBANK-1:0]     sel;
	logic [bank_pkg::NBANK-1:0]     pre_hit;
	logic [bank_pkg::NBANK-1:0]     ras_ok;
	logic [bank_pkg::NBANK-1:0]     ap_arm;
	logic [bank_pkg::NBANK-1:0]     ap_fire;
	logic [bank_pkg::NBANK-1:0]     ap_pend_r;
	logic [bank_pkg::TMR_W-1:0]     ap_cnt_r [bank_pkg::NBANK];
	logic                           wr_live_r;
	logic [1:0]                     wr_ba_r;
	logic [bank_pkg::COL_W-1:0]     wr_col_r;
	logic [4:0]                     wr_left_r;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	function automatic logic [bank_pkg::NBANK-1:0] onehot(input logic [1:0] ba);
		onehot = 4'h1 << ba;
	endfunction

	function automatic logic [bank_pkg::DQ_W-1:0] lane_en(input logic [3:0] m);
		logic [bank_pkg::DQ_W-1:0] e;
		e = '0;
		for (int i = 0; i < bank_pkg::LANES; i++) begin
			e[i*8 +: 8] = {8{~m[i]}};
		end
		lane_en = e;
	endfunction

	assign cmd_ok  = cke;
	assign is_act  = cmd_ok && cmd_in.cmd == bank_pkg::CMD_ACT;
	assign is_rd   = cmd_ok && cmd_in.cmd == bank_pkg::CMD_RD;
	assign is_wr   = cmd_ok && cmd_in.cmd == bank_pkg::CMD_WR;
	assign is_pre  = cmd_ok && cmd_in.cmd == bank_pkg::CMD_PRE;
	assign is_ref  = cmd_ok && cmd_in.cmd == bank_pkg::CMD_REF;
	assign ap_flag = cmd_in.addr[bank_pkg::AP_BIT];
	assign sel     = onehot(cmd_in.ba);

	// ---------------------------------------------------------------
	// explicit precharge: bit 10 picks one bank or all
	// ---------------------------------------------------------------
	always_comb begin
		pre_hit = '0;
		if (is_pre) begin
			pre_hit = ap_flag ? 4'hF : sel;
		end
	end

	// ---------------------------------------------------------------
	// per-bank state and auto precharge scheduling
	// ---------------------------------------------------------------
	for (genvar b = 0; b < bank_pkg::NBANK; b++) begin : g_bank
		logic pre_eff;

		// idle or closing bank ignores precharge; no row-active lock-out on explicit precharge
		assign pre_eff = pre_hit[b] && bank_state[b] == bank_pkg::BK_ACT;
		assign ap_arm[b] = (is_rd || is_wr) && ap_flag && sel[b]
			&& bank_state[b] == bank_pkg::BK_ACT;
		// fire once the burst/recovery delay has run and row-active time is met
		assign ap_fire[b] = ap_pend_r[b] && ap_cnt_r[b] == '0 && ras_ok[b];

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				ap_pend_r[b] <= 1'b0;
				ap_cnt_r[b]  <= '0;
			end else if (ap_arm[b]) begin
				ap_pend_r[b] <= 1'b1;
				if (is_rd) begin
					// burst-length/2 clocks to earliest full-burst precharge
					ap_cnt_r[b] <= bank_pkg::TMR_W'(burst_len >> 1) - 5'h01;
				end else begin
					// data pairs, then write recovery, never less than one clock
					ap_cnt_r[b] <= bank_pkg::TMR_W'(burst_len >> 1)
						+ bank_pkg::TMR_W'(bank_pkg::WR_CYC);
				end
			end else if (ap_fire[b]) begin
				ap_pend_r[b] <= 1'b0;
			end else if (ap_cnt_r[b] != '0) begin
				ap_cnt_r[b] <= ap_cnt_r[b] - 5'h01;
			end
		end

		bank_timer u_bank (
			.clk       (clk),
			.rst_b     (rst_b),
			.act_i     (is_act && sel[b]),
			.pre_i     (pre_eff && !ap_pend_r[b]),
			.ap_arm_i  (ap_arm[b]),
			.ap_fire_i (ap_fire[b]),
			.state_o   (bank_state[b]),
			.ras_ok_o  (ras_ok[b])
		);

		// pending close with row-active time not yet met keeps the row open
		a_ap_lockout: assert property (@(posedge clk) disable iff (!rst_b)
			(ap_pend_r[b] && !ras_ok[b]) |=> bank_state[b] == bank_pkg::BK_ACT)
			else $error("auto precharge before row-active time");
		a_pre_noop: assert property (@(posedge clk) disable iff (!rst_b)
			(pre_hit[b] && bank_state[b] == bank_pkg::BK_IDLE) |=> bank_state[b] == bank_pkg::BK_IDLE)
			else $error("precharge to idle bank changed state");
	end

	// other banks stay free: an activate to another idle bank goes through while bank 0 has an auto precharge pending
	a_concurrent: assert property (@(posedge clk) disable iff (!rst_b)
		(ap_pend_r[0] && is_act && cmd_in.ba != 2'h0
			&& bank_state[cmd_in.ba] == bank_pkg::BK_IDLE)
		|=> bank_state[$past(cmd_in.ba)] == bank_pkg::BK_ACT)
		else $error("command to other bank lost during auto precharge");

	// ---------------------------------------------------------------
	// write burst tracking and truncation
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_live_r <= 1'b0;
			wr_ba_r   <= 2'h0;
			wr_col_r  <= '0;
			wr_left_r <= 5'h00;
		end else if (is_wr) begin
			wr_live_r <= 1'b1;
			wr_ba_r   <= cmd_in.ba;
			wr_col_r  <= cmd_in.addr[bank_pkg::COL_W-1:0];
			wr_left_r <= burst_len;
		end else if (is_rd || (is_pre && (pre_hit[wr_ba_r]))) begin
			// truncation: later elements never reach the array
			wr_live_r <= 1'b0;
		end else if (wd_valid && wr_live_r) begin
			wr_col_r  <= wr_col_r + 10'h001;
			wr_left_r <= wr_left_r - 5'h01;
			if (wr_left_r == 5'h01) begin
				wr_live_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// array write port
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			arr_we     <= 1'b0;
			arr_ba     <= 2'h0;
			arr_col    <= '0;
			arr_data   <= '0;
			arr_bit_en <= '0;
		end else begin
			arr_we     <= wd_valid && wr_live_r && !is_rd && !is_pre;
			arr_ba     <= wr_ba_r;
			arr_col    <= wr_col_r;
			arr_data   <= wd_in.data;
			arr_bit_en <= lane_en(wd_in.mask);
		end
	end

	a_mask_lane: assert property (@(posedge clk) disable iff (!rst_b)
		wd_valid && wd_in.mask[0] |=> arr_bit_en[7:0] == 8'h00)
		else $error("masked lane 0 written");
	// burst closed first, then the array port falls quiet
	sequence s_wr_stopped;
		!wr_live_r ##1 !arr_we;
	endsequence

	a_trunc_stop: assert property (@(posedge clk) disable iff (!rst_b)
		(is_pre && wr_live_r && pre_hit[wr_ba_r]) |=> s_wr_stopped)
		else $error("write continued after precharge truncation");

	// ---------------------------------------------------------------
	// refresh
	// ---------------------------------------------------------------
	refresh_ctr u_ref (
		.clk    (clk),
		.rst_b  (rst_b),
		.ref_i  (is_ref && !ref_busy),
		.row_o  (ref_row),
		.busy_o (ref_busy)
	);

	a_ref_busy: assert property (@(posedge clk) disable iff (!rst_b)
		(is_ref && !ref_busy) |=> ref_busy [*8])
		else $error("refresh busy dropped early");

endmodule

// *** test/ctrl_model.sv ***
// ctrl_model: controller side of bank_ctrl, drives commands and write data.
// assumes the bench calls one task at a time, just after a rising edge.
module ctrl_model (
	// clock
	input  wire logic          clk,
	// commands
	output logic               cke,
	output bank_pkg::cmd_bus_t cmd_in,
	// write data
	output logic               wd_valid,
	output bank_pkg::wdata_t   wd_in,
	output logic [4:0]         burst_len
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] seed = 32'h00001464;
	logic        in_ref = 1'b0;

	initial begin
		cke = 1'b1;
		cmd_in = {bank_pkg::CMD_NOP, 15'(rnd())};
		wd_valid = 1'b0;
		wd_in = {rnd(), 4'hF};
		burst_len = 5'h04;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// idle cycles carry junk, so a stale value never passes for a real one
	task automatic step(input bank_pkg::cmd_t op, input logic [1:0] ba, input logic [12:0] a,
			input logic v, input logic [3:0] m, input logic ck);
		logic [31:0] r;
		@(posedge clk);
		#1;
		r = rnd();
		// clock enable is free on plain idle cycles, held high for data and refresh
		cke = (op == bank_pkg::CMD_NOP && !v && !in_ref) ? r[15] : ck;
		cmd_in.cmd = op;
		cmd_in.ba = (op == bank_pkg::CMD_NOP) ? r[1:0] : ba;
		cmd_in.addr = (op == bank_pkg::CMD_NOP) ? r[14:2] : a;
		wd_valid = v;
		wd_in = {rnd(), v ? m : ~wd_in.mask};
	endtask

	task automatic send(input bank_pkg::cmd_t op, input logic [1:0] ba, input logic [12:0] a,
			input logic ck);
		step(op, ba, a, 1'b0, 4'hF, ck);
		step(bank_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0, 4'hF, 1'b1);
	endtask

	task automatic idle(input int n);
		repeat (n) step(bank_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0, 4'hF, 1'b1);
	endtask

	task automatic set_bl(input logic [4:0] v);
		burst_len = v;
	endtask

	// a cut burst keeps strobing, with every later element masked
	task automatic write(input logic [1:0] ba, input logic [12:0] a, input int cut);
		logic [31:0] r;
		step(bank_pkg::CMD_WR, ba, a, 1'b0, 4'hF, 1'b1);
		for (int i = 0; i < burst_len; i++) begin
			r = rnd();
			step((i == cut) ? bank_pkg::CMD_PRE : bank_pkg::CMD_NOP, ba, 13'h0000, 1'b1,
				(i < cut) ? r[3:0] : 4'hF, 1'b1);
		end
		// one device only, so the recovery and turnaround waits are never skipped
		idle(bank_pkg::WR_CYC + 1);
	endtask

	task automatic refresh();
		logic [31:0] r;
		r = rnd();
		in_ref = 1'b1;
		send(bank_pkg::CMD_PRE, 2'h0, 13'h0400, 1'b1);
		idle(bank_pkg::RP_CYC);
		send(bank_pkg::CMD_REF, r[1:0], r[14:2], 1'b1);
		idle(bank_pkg::RFC_CYC + 1);
		in_ref = 1'b0;
	endtask
endmodule

// *** test/bank_ctrl_tb.sv ***
// bank_ctrl_tb: self-checking bench for bank_ctrl against a write-path model.
// assumes bank_pkg timing constants and a 125 MHz clock.
module bank_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                       clk = 1'b0;
	logic                       rst_b = 1'b0;
	logic                       cke, wd_valid, arr_we, ref_busy;
	logic [4:0]                 burst_len;
	logic [1:0]                 arr_ba;
	logic [9:0]                 arr_col;
	logic [31:0]                arr_data, arr_bit_en;
	logic [12:0]                ref_row, row0;
	bank_pkg::cmd_bus_t         cmd_in;
	bank_pkg::wdata_t           wd_in;
	bank_pkg::bank_st_t         bank_state [bank_pkg::NBANK];
	bank_pkg::wdata_t           exp_wr [int];
	int                         fail_count = 0;
	int                         samples_checked = 0;
	int                         wr_exp = 0;
	int                         wr_seen = 0;
	int                         wr_key = 0;

	always #4 clk = ~clk;

	ctrl_model ctrl_model_i (.clk(clk), .cke(cke), .cmd_in(cmd_in), .wd_valid(wd_valid),
		.wd_in(wd_in), .burst_len(burst_len));

	bank_ctrl bank_ctrl_i (.clk(clk), .rst_b(rst_b), .cke(cke), .cmd_in(cmd_in),
		.wd_valid(wd_valid), .wd_in(wd_in), .burst_len(burst_len), .arr_we(arr_we),
		.arr_ba(arr_ba), .arr_col(arr_col), .arr_data(arr_data), .arr_bit_en(arr_bit_en),
		.bank_state(bank_state), .ref_busy(ref_busy), .ref_row(ref_row));

	// ---------------------------------------------------------------
	// checks and the write-path model
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [31:0] lanes(input logic [3:0] m);
		for (int i = 0; i < 4; i++)
			lanes[8*i +: 8] = m[i] ? 8'h00 : 8'hFF;
	endfunction

	always @(posedge clk) begin
		bank_pkg::wdata_t e;
		if (rst_b && cke && cmd_in.cmd == bank_pkg::CMD_WR)
			wr_key = {cmd_in.ba, cmd_in.addr[9:0]};
		if (arr_we === 1'b1) begin
			if (!exp_wr.exists({arr_ba, arr_col}))
				chk("arr_col", 32'h0, 32'h1);
			else begin
				e = exp_wr[{arr_ba, arr_col}];
				chk("arr_bit_en", lanes(e.mask), arr_bit_en);
				chk("arr_data", e.data & lanes(e.mask), arr_data & arr_bit_en);
				wr_seen += (arr_bit_en != 32'h0);
			end
		end
		if (rst_b && wd_valid) begin
			exp_wr[wr_key] = wd_in;
			wr_exp += (wd_in.mask != 4'hF);
			wr_key++;
		end
	end

	task automatic st(input int b, input bank_pkg::bank_st_t s);
		chk("bank_state", {30'h0, s}, {30'h0, bank_state[b]});
	endtask

	// n counts edges from the one taking the command; the state is registered
	task automatic wait_pre(input int b, input int d);
		int n;
		n = 1;
		while (bank_state[b] !== bank_pkg::BK_PRE && n <= d + 3) begin
			@(posedge clk);
			#2;
			n++;
		end
		chk("pre_delay", d + 1, n);
		n = 0;
		while (bank_state[b] === bank_pkg::BK_PRE && n < 20) begin
			@(posedge clk);
			#2;
			n++;
		end
		chk("pre_len", bank_pkg::RP_CYC, n);
		st(b, bank_pkg::BK_IDLE);
	endtask

	task automatic act(input logic [1:0] b);
		ctrl_model_i.send(bank_pkg::CMD_ACT, b, 13'h0123, 1'b1);
		ctrl_model_i.idle(1);
		st(b, bank_pkg::BK_ACT);
	endtask

	task automatic tally_and_finish();
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// the run needs under two hundred cycles; reaching the 5000-cycle limit means a hang
	initial begin
		#40000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		repeat (12) @(posedge clk);
		#1;
		for (int b = 0; b < 4; b++) st(b, bank_pkg::BK_IDLE);
		chk("ref_busy", 32'h0, {31'h0, ref_busy});
		rst_b = 1'b1;
		ctrl_model_i.send(bank_pkg::CMD_ACT, 2'h0, 13'h0000, 1'b0);
		ctrl_model_i.idle(1);
		st(0, bank_pkg::BK_IDLE);
		act(2'h0);
		act(2'h1);
		ctrl_model_i.idle(bank_pkg::RAS_CYC);
		ctrl_model_i.send(bank_pkg::CMD_PRE, 2'h1, 13'h0000, 1'b1);
		wait_pre(1, 0);
		st(0, bank_pkg::BK_ACT);
		ctrl_model_i.send(bank_pkg::CMD_PRE, 2'h1, 13'h0000, 1'b1);
		ctrl_model_i.idle(1);
		st(1, bank_pkg::BK_IDLE);
		act(2'h2);
		ctrl_model_i.idle(bank_pkg::RAS_CYC);
		ctrl_model_i.send(bank_pkg::CMD_PRE, 2'h3, 13'h0400, 1'b1);
		fork
			wait_pre(0, 0);
			wait_pre(2, 0);
		join
		st(3, bank_pkg::BK_IDLE);
		ctrl_model_i.set_bl(5'h02);
		ctrl_model_i.send(bank_pkg::CMD_ACT, 2'h0, 13'h0010, 1'b1);
		ctrl_model_i.send(bank_pkg::CMD_RD, 2'h0, 13'h0400, 1'b1);
		wait_pre(0, bank_pkg::RAS_CYC - 2);
		ctrl_model_i.set_bl(5'h08);
		act(2'h0);
		ctrl_model_i.idle(bank_pkg::RAS_CYC);
		ctrl_model_i.send(bank_pkg::CMD_RD, 2'h0, 13'h0400, 1'b1);
		fork
			wait_pre(0, 4);
			ctrl_model_i.send(bank_pkg::CMD_ACT, 2'h1, 13'h0020, 1'b1);
		join
		st(1, bank_pkg::BK_ACT);
		ctrl_model_i.set_bl(5'h04);
		act(2'h0);
		ctrl_model_i.idle(bank_pkg::RAS_CYC);
		fork
			ctrl_model_i.write(2'h0, 13'h0400, 99);
			begin
				repeat (2) @(posedge clk);
				#1;
				// two pairs, the first edge after the last pair, then recovery
				wait_pre(0, 3 + bank_pkg::WR_CYC);
			end
		join
		ctrl_model_i.set_bl(5'h08);
		ctrl_model_i.write(2'h1, 13'h0040, 2);
		st(1, bank_pkg::BK_IDLE);
		repeat (2) begin
			row0 = ref_row;
			fork
				ctrl_model_i.refresh();
				begin
					int n;
					n = 0;
					repeat (30) begin
						@(posedge clk);
						#2;
						n += ref_busy;
					end
					chk("ref_busy_len", bank_pkg::RFC_CYC, n);
				end
			join
			chk("ref_row", {19'h0, row0 + 13'h0001}, {19'h0, ref_row});
		end
		chk("writes", wr_exp, wr_seen);
		tally_and_finish();
	end
endmodule
